/* File: design/ssrq_consts.svh */
`ifndef SSRQ_CONSTS_SVH
`define SSRQ_CONSTS_SVH
// Register byte offsets on the AHB-Lite slave.
`define SSRQ_OFF_STB_POLL   12'h000
`define SSRQ_OFF_STB_QUERY  12'h004
`define SSRQ_OFF_SRE        12'h008
`define SSRQ_OFF_CLS        12'h00C
`define SSRQ_OFF_QUES_COND  12'h010
`define SSRQ_OFF_QUES_EVT   12'h014
`define SSRQ_OFF_QUES_ENA   12'h018
`define SSRQ_OFF_OPER_COND  12'h020
`define SSRQ_OFF_OPER_EVT   12'h024
`define SSRQ_OFF_OPER_ENA   12'h028
`define SSRQ_OFF_ESR_EVT    12'h030
`define SSRQ_OFF_ESR_ENA    12'h034
// Status byte bit positions.
`define SSRQ_STB_QUES       3
`define SSRQ_STB_MAV        4
`define SSRQ_STB_ESB        5
`define SSRQ_STB_RQS        6
`define SSRQ_STB_OPER       7
// Implemented bits of each set.
`define SSRQ_QUES_MASK      16'h0101
`define SSRQ_OPER_MASK      16'h0370
`define SSRQ_ESR_MASK       8'hBD
`define SSRQ_SRE_MASK       8'hBF
`define SSRQ_ENA16_MASK     16'h7FFF
// Reset values.
`define SSRQ_RST16          16'h0000
`define SSRQ_RST8           8'h00
`endif

/* File: design/ssrq_pkg.sv */
`default_nettype none
package ssrq_pkg;
  // Status inputs of the three reporting sets plus the output queue.
  typedef struct packed {
    logic [15:0] ques;
    logic [15:0] oper;
    logic [7:0]  esr_evt;
    logic        mav;
  } ssrq_cond_t;
endpackage
`default_nettype wire

/* File: design/ssrq_top.sv */
// Contract
// - Status byte and standard event 8 bits, others 16 with bit 15 zero.
// - Condition bits follow conditions live, never latched.
// - Condition registers are read-only; writes ignored.
// - A condition change sets the event bit, held until cleared.
// - Reading an event register clears it; clear-status clears all.
// - Event registers change only by conditions and clearing.
// - Summary bit is OR of event AND enable over all bits.
// - Enable registers read back the last value written, except bit 15 and service enable bit 6, which read zero.
// - Request starts on enabled summary rise with none pending.
// - Request pending until serial poll reads the status byte.
// - Starting a request raises SRQ and sets RQS.
// - Serial poll returns status byte then clears only RQS.
// - Bit 6 is RQS by serial poll, MSS by status query.
// - Four register sets exist; unassigned bits read zero except in the enable registers.
// - Other sets feed summary bits into the status byte.
// - Status byte bits except bit 6 are live condition bits.
// - Service enable bit 6 reads zero and enables nothing.
// - Summaries at bits 3,4,5,6,7 of the status byte.
// - Clear-status zeroes event registers, keeps enable registers.
`include "ssrq_consts.svh"
`default_nettype none
module ssrq_top (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              nrst,
  // AHB-Lite slave.
  input  wire logic              hsel,
  input  wire logic [11:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Monitored conditions.
  input  wire ssrq_pkg::ssrq_cond_t cond,
  // Bus service request line, open drain, enable low while driving.
  output logic                   srq_o,
  output logic                   srq_oe_n
);

  // ------------------------------------------------------------------
  // Bus address phase capture
  // ------------------------------------------------------------------
  logic        ph_act_ff;
  logic        ph_wr_ff;
  logic [11:0] ph_addr_ff;
  logic        nxt_ph_act;

  // Nonsequential or sequential transfers are taken, whatever their hsize.
  assign nxt_ph_act = hsel & hready & htrans[1];

  // Transfer-in-flight flag. Only this flag decides whether the data phase
  // has any side effect, so it is the one that matters out of reset.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_act_ff <= 1'b0;
    end else begin
      ph_act_ff <= nxt_ph_act;
    end
  end

  // Direction and offset of the last address phase. They are captured every
  // cycle; while ph_act_ff is low their value is never looked at.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_wr_ff   <= 1'b0;
      ph_addr_ff <= 12'h000;
    end else begin
      ph_wr_ff   <= hwrite;
      ph_addr_ff <= haddr;
    end
  end

  logic rd_stb;
  logic wr_stb;
  assign rd_stb = ph_act_ff & ~ph_wr_ff;
  assign wr_stb = ph_act_ff & ph_wr_ff;

  // ------------------------------------------------------------------
  // Condition and event registers
  // ------------------------------------------------------------------
  logic [15:0] ques_cond;
  logic [15:0] oper_cond;
  logic [15:0] ques_prev_ff;
  logic [15:0] oper_prev_ff;
  logic [15:0] ques_evt_ff;
  logic [15:0] oper_evt_ff;
  logic [7:0]  esr_evt_ff;
  logic [15:0] ques_ena_ff;
  logic [15:0] oper_ena_ff;
  logic [7:0]  esr_ena_ff;
  logic [7:0]  sre_ena_ff;

  // live conditions: unused bits and bit 15 are forced to zero.
  assign ques_cond = cond.ques & `SSRQ_QUES_MASK;
  assign oper_cond = cond.oper & `SSRQ_OPER_MASK;

  // Previous condition values, used to see any change.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ques_prev_ff <= `SSRQ_RST16;
      oper_prev_ff <= `SSRQ_RST16;
    end else begin
      ques_prev_ff <= ques_cond;
      oper_prev_ff <= oper_cond;
    end
  end

  logic cls_stb;
  logic rd_ques_evt;
  logic rd_oper_evt;
  logic rd_esr_evt;
  assign cls_stb     = wr_stb & (ph_addr_ff == `SSRQ_OFF_CLS);
  assign rd_ques_evt = rd_stb & (ph_addr_ff == `SSRQ_OFF_QUES_EVT);
  assign rd_oper_evt = rd_stb & (ph_addr_ff == `SSRQ_OFF_OPER_EVT);
  assign rd_esr_evt  = rd_stb & (ph_addr_ff == `SSRQ_OFF_ESR_EVT);

  logic [15:0] ques_set;
  logic [15:0] oper_set;
  logic [7:0]  esr_set;
  // any edge of a condition latches its event bit.
  assign ques_set = ques_cond ^ ques_prev_ff;
  assign oper_set = oper_cond ^ oper_prev_ff;
  assign esr_set  = cond.esr_evt & `SSRQ_ESR_MASK;

  logic [15:0] ques_clr;
  logic [15:0] oper_clr;
  logic [7:0]  esr_clr;
  // a read clears only the bits that it handed back, which still stand in
  // hrdata during the data phase. An event that lands between the capture and
  // the clear is kept for the next read instead of being lost.
  assign ques_clr = cls_stb ? 16'hFFFF : (rd_ques_evt ? hrdata[15:0] : 16'h0000);
  assign oper_clr = cls_stb ? 16'hFFFF : (rd_oper_evt ? hrdata[15:0] : 16'h0000);
  assign esr_clr  = cls_stb ? 8'hFF : (rd_esr_evt ? hrdata[7:0] : 8'h00);

  // questionable events change only by a condition edge or a clear.
  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ques_evt_ff <= `SSRQ_RST16;
    end else begin
      ques_evt_ff <= (ques_evt_ff & ~ques_clr) | ques_set;
    end
  end

  // operational events change only by a condition edge or a clear.
  // The set term is ORed last, so the set wins over a clear in one cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oper_evt_ff <= `SSRQ_RST16;
    end else begin
      oper_evt_ff <= (oper_evt_ff & ~oper_clr) | oper_set;
    end
  end

  // standard events are set by any cycle with the input high.
  // A held-high input therefore sets the bit again right after a clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      esr_evt_ff <= `SSRQ_RST8;
    end else begin
      esr_evt_ff <= (esr_evt_ff & ~esr_clr) | esr_set;
    end
  end

  // ------------------------------------------------------------------
  // Enable registers
  // ------------------------------------------------------------------
  logic wr_ques_ena;
  logic wr_oper_ena;
  logic wr_esr_ena;
  logic wr_sre;
  // Write strobes, one per enable register, taken in the data phase.
  assign wr_ques_ena = wr_stb & (ph_addr_ff == `SSRQ_OFF_QUES_ENA);
  assign wr_oper_ena = wr_stb & (ph_addr_ff == `SSRQ_OFF_OPER_ENA);
  assign wr_esr_ena  = wr_stb & (ph_addr_ff == `SSRQ_OFF_ESR_ENA);
  assign wr_sre      = wr_stb & (ph_addr_ff == `SSRQ_OFF_SRE);

  // questionable enable; clear-status leaves it alone.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ques_ena_ff <= `SSRQ_RST16;
    end else if (wr_ques_ena) begin
      ques_ena_ff <= hwdata[15:0] & `SSRQ_ENA16_MASK;
    end
  end

  // operational enable; bit 15 never sticks.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oper_ena_ff <= `SSRQ_RST16;
    end else if (wr_oper_ena) begin
      oper_ena_ff <= hwdata[15:0] & `SSRQ_ENA16_MASK;
    end
  end

  // standard event enable, all eight bits kept.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      esr_ena_ff <= `SSRQ_RST8;
    end else if (wr_esr_ena) begin
      esr_ena_ff <= hwdata[7:0];
    end
  end

  // bit 6 of the service enable never sticks, so MSS cannot feed itself.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sre_ena_ff <= `SSRQ_RST8;
    end else if (wr_sre) begin
      sre_ena_ff <= hwdata[7:0] & `SSRQ_SRE_MASK;
    end
  end

  // ------------------------------------------------------------------
  // Summaries and status byte
  // ------------------------------------------------------------------
  logic       ques_sum;
  logic       oper_sum;
  logic       esr_sum;
  logic [7:0] stb_live;
  logic       mss;

  // summary is the OR of enabled events.
  assign ques_sum = |(ques_evt_ff & ques_ena_ff);
  assign oper_sum = |(oper_evt_ff & oper_ena_ff);
  assign esr_sum  = |(esr_evt_ff & esr_ena_ff);

  // summaries placed as live bits of the status byte.
  always_comb begin
    stb_live                 = 8'h00;
    stb_live[`SSRQ_STB_QUES] = ques_sum;
    stb_live[`SSRQ_STB_MAV]  = cond.mav;
    stb_live[`SSRQ_STB_ESB]  = esr_sum;
    stb_live[`SSRQ_STB_OPER] = oper_sum;
  end

  // master summary for the status query.
  assign mss = |(stb_live & sre_ena_ff);

  // ------------------------------------------------------------------
  // Service request
  // ------------------------------------------------------------------
  logic [7:0] stb_prev_ff;
  logic       rqs_ff;
  logic       poll_stb;
  logic       start_req;

  assign poll_stb = rd_stb & (ph_addr_ff == `SSRQ_OFF_STB_POLL);

  // rising enabled summary starts a request if none is pending.
  assign start_req = |(stb_live & ~stb_prev_ff & sre_ena_ff) & ~rqs_ff;

  // Previous status byte for the rising-edge test.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stb_prev_ff <= `SSRQ_RST8;
    end else begin
      stb_prev_ff <= stb_live;
    end
  end

  logic poll_clr;
  logic nxt_rqs;
  // a poll clears RQS only when the byte it returned showed RQS; a
  // request that began after the capture stays pending for the next poll.
  assign poll_clr = poll_stb & hrdata[`SSRQ_STB_RQS];
  // no request starts while one is pending, so start_req and poll_clr
  // fall in one cycle only on the second of back-to-back polls; start_req wins.
  assign nxt_rqs  = start_req | (rqs_ff & ~poll_clr);

  // pending request latched until a serial poll.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rqs_ff <= 1'b0;
    end else begin
      rqs_ff <= nxt_rqs;
    end
  end

  // the line follows the next pending state, so it changes at
  // the same edge as RQS. Only the enable toggles; the data stays low.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      srq_o    <= 1'b0;
      srq_oe_n <= 1'b1;
    end else begin
      srq_o    <= 1'b0;
      srq_oe_n <= ~nxt_rqs;
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  logic [31:0] nxt_rdata;

  // condition registers are read-only; unmapped reads give zero.
  // bit 6 shows RQS on the poll port and MSS on the query port.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (haddr)
      `SSRQ_OFF_STB_POLL:  nxt_rdata[7:0]  = stb_live | (rqs_ff ? 8'h40 : 8'h00);
      `SSRQ_OFF_STB_QUERY: nxt_rdata[7:0]  = stb_live | (mss ? 8'h40 : 8'h00);
      `SSRQ_OFF_SRE:       nxt_rdata[7:0]  = sre_ena_ff;
      `SSRQ_OFF_QUES_COND: nxt_rdata[15:0] = ques_cond;
      `SSRQ_OFF_QUES_EVT:  nxt_rdata[15:0] = ques_evt_ff;
      `SSRQ_OFF_QUES_ENA:  nxt_rdata[15:0] = ques_ena_ff;
      `SSRQ_OFF_OPER_COND: nxt_rdata[15:0] = oper_cond;
      `SSRQ_OFF_OPER_EVT:  nxt_rdata[15:0] = oper_evt_ff;
      `SSRQ_OFF_OPER_ENA:  nxt_rdata[15:0] = oper_ena_ff;
      `SSRQ_OFF_ESR_EVT:   nxt_rdata[7:0]  = esr_evt_ff;
      `SSRQ_OFF_ESR_ENA:   nxt_rdata[7:0]  = esr_ena_ff;
      default:             nxt_rdata       = 32'h0000_0000;
    endcase
  end

  // Read data is sampled at the address phase so the data phase needs no wait.
  // The value then stands until the next read, which the read-clear logic
  // relies on to know exactly which bits were handed back.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (nxt_ph_act & ~hwrite) begin
      hrdata <= nxt_rdata;
    end
  end

  // Zero wait state, always OKAY. Writes to read-only or unmapped offsets
  // are dropped quietly rather than answered with an error.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: dv/ssrq_ctrl_model.sv */
`default_nettype none
// ----
// Bus controller stand-in
// ----
module ssrq_ctrl_model (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic nrst,
  // Service request pin of the device.
  input  wire logic srq_o,
  input  wire logic srq_oe_n,
  // Resolved line and poll demand.
  output logic      srq_line,
  output logic      poll_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // The line has a pull-up, so a released pin reads high.
  assign srq_line = srq_oe_n ? 1'b1 : srq_o;
  // poll on request
  // A low line asks for a serial poll; the bench then reads the poll port.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      poll_req <= 1'b0;
    end else begin
      poll_req <= !srq_line;
    end
  end
endmodule
`default_nettype wire

/* File: dv/ssrq_sva.sv */
`default_nettype none
// ----
// Checker on the top ports
// ----
module ssrq_sva (
  // Clock and reset.
  input wire logic                 clk,
  input wire logic                 nrst,
  // Bus side.
  input wire logic                 hsel,
  input wire logic                 hready,
  input wire logic                 hwrite,
  input wire logic [1:0]           htrans,
  input wire logic [11:0]          haddr,
  input wire logic [31:0]          hrdata,
  // Status side.
  input wire ssrq_pkg::ssrq_cond_t cond,
  input wire logic                 srq_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        rd_ff;
  logic [11:0] a_ff;
  logic        poll;
  // Read data is judged in the data phase, one edge after the address.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_ff <= 1'b0;
      a_ff  <= 12'h000;
    end else begin
      rd_ff <= hsel && hready && htrans[1] && !hwrite;
      a_ff  <= haddr;
    end
  end
  // A serial poll is a read of the first status port.
  assign poll = rd_ff && a_ff == 12'h000;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_hold; !srq_oe_n && !poll |=> !srq_oe_n; endproperty
  a_hold: assert property (p_hold) else $error("request line dropped");
  property p_rqs; poll |-> hrdata[6] == !$past(srq_oe_n); endproperty
  a_rqs: assert property (p_rqs) else $error("poll bit 6 wrong");
  property p_clr; poll && hrdata[6] |=> srq_oe_n; endproperty
  a_clr: assert property (p_clr) else $error("poll left request");
  property p_stb; rd_ff && a_ff[11:3] == 9'h000 |-> hrdata[2:0] == 3'h0 && hrdata[31:8] == '0;
  endproperty
  a_stb: assert property (p_stb) else $error("unused status bits set");
  property p_mav; rd_ff && a_ff == 12'h004 |-> hrdata[4] == $past(cond.mav); endproperty
  a_mav: assert property (p_mav) else $error("status bit 4 not live");
  property p_ques; rd_ff && a_ff == 12'h010 |-> hrdata == {16'h0000, $past(cond.ques) & 16'h0101};
  endproperty
  a_ques: assert property (p_ques) else $error("questionable condition wrong");
  property p_oper; rd_ff && a_ff == 12'h020 |-> hrdata == {16'h0000, $past(cond.oper) & 16'h0370};
  endproperty
  a_oper: assert property (p_oper) else $error("operational condition wrong");
  property p_rst; $rose(nrst) |-> srq_oe_n; endproperty
  a_rst: assert property (p_rst) else $error("request line after reset");
endmodule
bind ssrq_top ssrq_sva ssrq_sva_inst (.clk, .nrst, .hsel, .hready, .hwrite, .htrans, .haddr,
  .hrdata, .cond, .srq_oe_n);
`default_nettype wire

/* File: dv/tb_top.sv */
`default_nettype none
// ----
// Bench top
// ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk, nrst, hsel, hwrite, rd_dp, hreadyout, hresp;
  logic                 srq_o, srq_oe_n, srq_line, poll_req;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  logic [11:0]          haddr;
  logic [31:0]          hwdata, hrdata, v;
  ssrq_pkg::ssrq_cond_t cond;
  logic [31:0]          expq[$];
  int                   failures, n_compared, seed, i;
  logic [11:0]          ea[4] = '{12'h008, 12'h018, 12'h028, 12'h034};
  logic [31:0]          em[4] = '{32'h0000_00bf, 32'h0000_7fff, 32'h0000_7fff, 32'h0000_00ff};
  ssrq_top ssrq_top_inst (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cond, .srq_o, .srq_oe_n);
  ssrq_ctrl_model ssrq_ctrl_model_inst (.clk, .nrst, .srq_o, .srq_oe_n, .srq_line, .poll_req);
  // Free-running bus clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One single transfer; every wait rides on the slave's ready.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp  <= !w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_dp  <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0000_0000);
  endtask
  // The request may take a few edges to reach the line.
  task automatic wait_srq;
    for (int k = 0; k < 50 && poll_req !== 1'b1; k++) @(posedge clk);
    chk(srq_line, 32'h0000_0000);
  endtask
  task automatic tally_and_finish;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Read data is compared in the data phase against the oldest note.
  always @(posedge clk) begin
    if (rd_dp && hreadyout === 1'b1) chk(hrdata, expq.pop_front());
  end
  // Cuts a hang short; the whole run needs well under this.
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    {nrst, hsel, hwrite, rd_dp, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    cond  = '0;
    seed  = 32'h0000_c2cb;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(srq_line, 32'h0000_0001);
    for (i = 0; i < 4; i++) rd(ea[i], 32'h0000_0000);
    cond.ques <= 16'($random(seed));
    cond.oper <= 16'($random(seed));
    cond.mav  <= 1'b1;
    repeat (2) @(posedge clk);
    xfer(1'b1, 12'h010, 32'hffff_ffff);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    rd(12'h010, {16'h0000, cond.ques & 16'h0101});
    rd(12'h020, {16'h0000, cond.oper & 16'h0370});
    rd(12'h024, {16'h0000, cond.oper & 16'h0370});
    rd(12'h004, 32'h0000_0010);
    cond.mav <= 1'b0;
    xfer(1'b1, 12'h00c, 32'h0000_0000);
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      xfer(1'b1, ea[i], v);
      rd(ea[i], v & em[i]);
      xfer(1'b1, ea[i], 32'h0000_0000);
    end
    cond.ques[0] <= ~cond.ques[0];
    @(posedge clk);
    cond.ques[0] <= ~cond.ques[0];
    repeat (2) @(posedge clk);
    xfer(1'b1, 12'h014, 32'hffff_ffff);
    rd(12'h014, 32'h0000_0001);
    rd(12'h014, 32'h0000_0000);
    for (i = 0; i < 2; i++) begin
      cond.esr_evt <= 8'hff;
      @(posedge clk);
      cond.esr_evt <= 8'h00;
      repeat (2) @(posedge clk);
      xfer(1'b1, 12'h034, 32'h0000_0021);
      rd(12'h004, 32'h0000_0020);
      if (i == 0) rd(12'h030, 32'h0000_00bd);
    end
    xfer(1'b1, 12'h00c, 32'h0000_0000);
    rd(12'h030, 32'h0000_0000);
    rd(12'h034, 32'h0000_0021);
    xfer(1'b1, 12'h034, 32'h0000_0000);
    xfer(1'b1, 12'h018, 32'h0000_0100);
    xfer(1'b1, 12'h008, 32'h0000_0008);
    cond.ques[8] <= ~cond.ques[8];
    wait_srq();
    rd(12'h004, 32'h0000_0048);
    rd(12'h000, 32'h0000_0048);
    rd(12'h000, 32'h0000_0008);
    chk(srq_line, 32'h0000_0001);
    rd(12'h014, 32'h0000_0100);
    cond.ques[8] <= ~cond.ques[8];
    wait_srq();
    rd(12'h000, 32'h0000_0048);
    tally_and_finish();
  end
endmodule
`default_nettype wire
